// ### lcd_panel.sv
`timescale 1ns/1ps
module lcd_panel (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       pins_owned_in,
  output logic      [3:0] frames_out
);
  logic was_owned;
  // a frame is over once the controller hands the pins back
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      was_owned  <= 1'b0;
      frames_out <= 4'h0;
    end else begin
      was_owned <= pins_owned_in;
      if (was_owned && !pins_owned_in) frames_out <= frames_out + 4'h1;
    end
  end
endmodule

// ### pin_order_monitor.sv
`timescale 1ns/1ps
module pin_order_monitor (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic display_enable_bit_in,
  input wire logic done_irq_mask_in,
  input wire logic done_clear_in,
  input wire logic subpix_ready_out,
  input wire logic pins_owned_out,
  input wire logic disable_done_flag_out,
  input wire logic done_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence run_start;
    $rose(display_enable_bit_in) && !pins_owned_out;
  endsequence
  sequence frame_done;
    $fell(pins_owned_out) && !$past(display_enable_bit_in);
  endsequence
  irq_unmasked_a: assert property (
    disable_done_flag_out && !$past(done_irq_mask_in) |-> done_irq_out)
    else $error("irq missing");
  irq_masked_a: assert property ($past(done_irq_mask_in) |-> !done_irq_out)
    else $error("irq not masked");
  irq_flag_a: assert property (done_irq_out |-> disable_done_flag_out)
    else $error("irq without flag");
  flag_cause_a: assert property ($rose(disable_done_flag_out) |-> frame_done)
    else $error("flag before frame end");
  flag_sticky_a: assert property (
    $past(disable_done_flag_out) && !$past(done_clear_in) |-> disable_done_flag_out)
    else $error("flag lost");
  flag_clear_a: assert property (
    $past(done_clear_in) && !$fell(pins_owned_out) |-> !disable_done_flag_out)
    else $error("flag not cleared");
  run_start_a: assert property (run_start |-> ##[1:2] pins_owned_out)
    else $error("no start");
  idle_refuse_a: assert property (!pins_owned_out |-> !subpix_ready_out)
    else $error("ready while stopped");
endmodule
bind pin_order_out pin_order_monitor u_chk (.clk_in, .rst_b_in, .display_enable_bit_in,
  .done_irq_mask_in, .done_clear_in, .subpix_ready_out, .pins_owned_out,
  .disable_done_flag_out, .done_irq_out);

// ### pin_order_out.sv
`timescale 1ns/1ps
// What this block does
// - done flag only after disable and frame end
// - mask clear: flag high raises interrupt
// - mask set: interrupt suppressed
// - mask never touches the flag itself
// - colour dual: upper on data, lower on extra pins
// - disable mid-frame finishes frame, then done
module pin_order_out
  import pin_order_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                rst_b_in,
  input  wire logic                display_enable_bit_in,
  input  wire logic                done_irq_mask_in,
  input  wire logic                done_clear_in,
  input  wire pin_mode_t           mode_in,
  input  wire logic [SUBPIX_W-1:0] upper_subpix_in,
  input  wire logic [SUBPIX_W-1:0] lower_subpix_in,
  input  wire logic                frame_last_in,
  input  wire logic                subpix_valid_in,
  output logic                     subpix_ready_out,
  input  wire logic                pix_strobe_in,
  output logic [UPPER_PINS-1:0]    data_pins_out,
  output logic [LOWER_PINS-1:0]    gp_pins_out,
  output logic                     pins_owned_out,
  output logic                     disable_done_flag_out,
  output logic                     done_irq_out
);
  localparam int unsigned FILL_W = $clog2(FIFO_DEPTH) + 1;

  logic [FIFO_W-1:0]     fifo_data;
  logic                  fifo_valid;
  logic                  fifo_ready;
  logic                  fifo_push;
  logic                  running;
  logic                  stopping;
  logic                  subpix_ready;
  logic [FILL_W-1:0]     fill;
  logic                  disable_done_flag;
  logic [2:0]            up_pin;
  logic [2:0]            lo_pin;
  logic [UPPER_PINS-1:0] data_pins;
  logic [LOWER_PINS-1:0] gp_pins;
  logic                  done_irq;
  logic                  next_running;
  logic                  next_stopping;
  logic                  next_subpix_ready;
  logic [FILL_W-1:0]     next_fill;
  logic                  next_flag;
  logic [2:0]            next_up_pin;
  logic [2:0]            next_lo_pin;
  logic [UPPER_PINS-1:0] next_data_pins;
  logic [LOWER_PINS-1:0] next_gp_pins;
  logic                  next_irq;
  logic                  take;
  logic                  frame_end;
  logic                  stop_now;
  logic [SUBPIX_W-1:0]   up_val;
  logic [SUBPIX_W-1:0]   lo_val;

  function automatic logic [2:0] first_pin(input pin_mode_t m);
    first_pin = (m == MODE_COLOR_SINGLE || m == MODE_COLOR_DUAL) ? PIN_HIGH : PIN_LOW;
  endfunction

  function automatic logic [2:0] step_pin(input pin_mode_t m, input logic [2:0] p);
    unique case (m)
      MODE_MONO_SINGLE:  step_pin = (p == MONO4_LAST) ? PIN_LOW : p + 3'h1;
      MODE_MONO_DOUBLE:  step_pin = p + 3'h1;
      MODE_COLOR_SINGLE: step_pin = p - 3'h1;
      MODE_COLOR_DUAL:   step_pin = p - 3'h1;
    endcase
  endfunction

  pixel_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .wr_data_in   ({frame_last_in, upper_subpix_in, lower_subpix_in}),
    .wr_valid_in  (fifo_push),
    .wr_ready_out (),
    .rd_data_out  (fifo_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_ready)
  );

  assign fifo_push        = subpix_valid_in && subpix_ready;
  assign fifo_ready       = pix_strobe_in && running;
  assign subpix_ready_out = subpix_ready;
  assign pins_owned_out   = running;
  assign data_pins_out    = data_pins;
  assign gp_pins_out      = gp_pins;
  assign disable_done_flag_out = disable_done_flag;
  assign done_irq_out     = done_irq;

  // decode of the entry leaving the fifo
  always_comb begin
    take      = fifo_valid && fifo_ready;
    frame_end = take && fifo_data[FIFO_W-1];
    up_val    = fifo_data[2*SUBPIX_W-1:SUBPIX_W];
    lo_val    = fifo_data[SUBPIX_W-1:0];
    // frame in progress completes before the stop takes effect
    stop_now  = running && (stopping || !display_enable_bit_in) && frame_end;
  end

  always_comb begin
    next_running  = running;
    next_stopping = stopping;
    if (!running) begin
      if (display_enable_bit_in) begin
        next_running  = 1'b1;
        next_stopping = 1'b0;
      end
    end else if (!display_enable_bit_in) begin
      next_stopping = 1'b1;
    end
    if (stop_now) begin
      next_running  = 1'b0;
      next_stopping = 1'b0;
    end
  end

  // occupancy mirror of the fifo, so that ready can leave a flop
  always_comb begin
    next_fill = fill;
    if (fifo_push && !take) begin
      next_fill = fill + 1'b1;
    end else if (take && !fifo_push) begin
      next_fill = fill - 1'b1;
    end
    next_subpix_ready = next_running && (next_fill != FILL_W'(FIFO_DEPTH));
  end

  // pin index steps per mode; pins clear when they are handed back
  always_comb begin
    next_up_pin    = up_pin;
    next_lo_pin    = lo_pin;
    next_data_pins = data_pins;
    next_gp_pins   = gp_pins;
    if (!running) begin
      next_up_pin = first_pin(mode_in);
      next_lo_pin = first_pin(mode_in);
    end
    if (take) begin
      unique case (mode_in)
        MODE_COLOR_DUAL: begin
          next_data_pins[up_pin] = up_val[SUBPIX_W-1];
          next_gp_pins[lo_pin]   = lo_val[SUBPIX_W-1];
          next_up_pin = step_pin(mode_in, up_pin);
          next_lo_pin = step_pin(mode_in, lo_pin);
        end
        default: begin
          next_data_pins[up_pin] = up_val[SUBPIX_W-1];
          next_up_pin = step_pin(mode_in, up_pin);
        end
      endcase
      if (frame_end) begin
        next_up_pin = first_pin(mode_in);
        next_lo_pin = first_pin(mode_in);
      end
    end
    if (stop_now) begin
      next_data_pins = PINS_RESET;
      next_gp_pins   = PINS_RESET;
    end
  end

  // set wins over clear; mask gates only the interrupt, not the flag
  always_comb begin
    next_flag = disable_done_flag;
    if (done_clear_in) begin
      next_flag = 1'b0;
    end
    if (stop_now) begin
      next_flag = 1'b1;
    end
    next_irq = next_flag && !done_irq_mask_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      running  <= 1'b0;
      stopping <= 1'b0;
    end else begin
      running  <= next_running;
      stopping <= next_stopping;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fill         <= '0;
      subpix_ready <= 1'b0;
    end else begin
      fill         <= next_fill;
      subpix_ready <= next_subpix_ready;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      up_pin    <= PIN_LOW;
      lo_pin    <= PIN_LOW;
      data_pins <= PINS_RESET;
      gp_pins   <= PINS_RESET;
    end else begin
      up_pin    <= next_up_pin;
      lo_pin    <= next_lo_pin;
      data_pins <= next_data_pins;
      gp_pins   <= next_gp_pins;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      disable_done_flag <= 1'b0;
      done_irq          <= 1'b0;
    end else begin
      disable_done_flag <= next_flag;
      done_irq          <= next_irq;
    end
  end
endmodule

// ### pin_order_pkg.sv
package pin_order_pkg;
  localparam int unsigned SUBPIX_W      = 4;
  localparam int unsigned UPPER_PINS    = 8;
  localparam int unsigned LOWER_PINS    = 8;
  localparam int unsigned FIFO_DEPTH    = 32;
  localparam int unsigned FIFO_W        = 2 * SUBPIX_W + 1;
  localparam logic [2:0]  PIN_HIGH      = 3'h7;
  localparam logic [2:0]  PIN_LOW       = 3'h0;
  localparam logic [2:0]  MONO4_LAST    = 3'h3;
  localparam logic [7:0]  PINS_RESET    = 8'h00;

  typedef enum logic [1:0] {
    MODE_MONO_SINGLE,
    MODE_MONO_DOUBLE,
    MODE_COLOR_SINGLE,
    MODE_COLOR_DUAL
  } pin_mode_t;
endpackage

// ### pixel_fifo.sv
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign wr_ready_out = (count != (AW+1)'(DEPTH));
  assign rd_valid_out = (count != '0);
  assign rd_data_out  = mem[rd_ptr];

  always_comb begin
    push        = wr_valid_in && wr_ready_out;
    pop         = rd_valid_out && rd_ready_in;
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pin_order_pkg::*;
  logic      clk_in, rst_b_in, en, mask, clr, valid, last, strobe, ready, owned, flag, irq;
  pin_mode_t mode;
  logic [3:0] up, lo, frames;
  logic [7:0] data, gp;
  int         n_mismatch = 0, samples_checked = 0, cycles = 0;
  pin_order_out u_dut (.clk_in, .rst_b_in, .display_enable_bit_in(en), .done_irq_mask_in(mask),
    .done_clear_in(clr), .mode_in(mode), .upper_subpix_in(up), .lower_subpix_in(lo),
    .frame_last_in(last), .subpix_valid_in(valid), .subpix_ready_out(ready),
    .pix_strobe_in(strobe), .data_pins_out(data), .gp_pins_out(gp), .pins_owned_out(owned),
    .disable_done_flag_out(flag), .done_irq_out(irq));
  lcd_panel u_panel (.clk_in, .rst_b_in, .pins_owned_in(owned), .frames_out(frames));
  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic push(input logic [3:0] u, input logic [3:0] l, input logic fl);
    int t;
    @(posedge clk_in);
    {valid, up, lo, last} <= {1'b1, u, l, fl};
    #1;
    for (t = 0; t < 50 && ready !== 1'b1; t++) @(posedge clk_in) #1;
    @(posedge clk_in);
    valid <= 1'b0;
  endtask
  task automatic tick();
    @(posedge clk_in);
    strobe <= 1'b1;
    @(posedge clk_in);
    strobe <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic run_frame(input pin_mode_t m, input int n, input logic mk);
    int k;
    int p;
    @(posedge clk_in);
    {mode, mask, en} <= {m, mk, 1'b1};
    repeat (2) @(posedge clk_in);
    #1;
    check(owned, 1, "start");
    for (k = 0; k < n; k++) push({k[0] ^ k[2], 3'h5}, {!k[1], 3'h2}, k == n - 1);
    #1;
    check(ready, n >= FIFO_DEPTH ? 0 : 1, "ready");
    @(posedge clk_in);
    en <= 1'b0;
    for (k = 0; k < n; k++) begin
      tick();
      p = (m == MODE_MONO_SINGLE) ? k % 4 : (m == MODE_MONO_DOUBLE) ? k % 8 : 7 - k % 8;
      if (k < n - 1) begin
        check(owned, 1, "mid frame");
        check(data[p], k[0] ^ k[2], "data pin");
        check(gp[p], (m == MODE_COLOR_DUAL) ? !k[1] : 0, "extra pin");
      end else begin
        check({owned, flag, irq}, {2'b01, ~mk}, "frame end");
        check(data, 8'h00, "data released");
        check(gp, 8'h00, "extra released");
      end
    end
    @(posedge clk_in);
    mask <= ~mk;
    repeat (2) @(posedge clk_in);
    #1;
    check({flag, irq}, {1'b1, mk}, "mask toggle");
    @(posedge clk_in);
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    @(posedge clk_in);
    #1;
    check({flag, irq}, 2'b00, "clear");
  endtask
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    {rst_b_in, en, mask, clr, valid, last, strobe, up, lo} = '0;
    mode = MODE_MONO_SINGLE;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    run_frame(MODE_COLOR_SINGLE, FIFO_DEPTH, 1'b0);
    run_frame(MODE_COLOR_DUAL, 19, 1'b1);
    run_frame(MODE_MONO_SINGLE, 9, 1'b0);
    run_frame(MODE_MONO_DOUBLE, 11, 1'b1);
    check(frames, 4, "frames");
    report_and_stop();
  end
endmodule
